/* File: core/uepa_regs.sv */
// endpoint A interrupt and dma setup registers behind an apb slave
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module uepa_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [uepa_pkg::UEPA_STRB_W-1:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire uepa_pkg::uepa_evt_s evt,
   output uepa_pkg::uepa_dma_cfg_s dma_cfg,
   output logic irq
);
   import uepa_pkg::*;

   // register state
   logic [UEPA_IRQ_W-1:0] irq_enable;
   logic [UEPA_IRQ_W-1:0] irq_status;
   logic [31:0] dma_address;
   logic [UEPA_LEN_W-1:0] dma_length;

   // handshake strobes from the slave
   logic setup_stb;
   logic access_stb;

   // address decode
   logic hit_enable;
   logic hit_clear;
   logic hit_status;
   logic hit_address;
   logic hit_length;
   logic hit_any;

   assign hit_enable = (paddr == UEPA_ADDR_IRQ_ENABLE);
   assign hit_clear = (paddr == UEPA_ADDR_IRQ_CLEAR);
   assign hit_status = (paddr == UEPA_ADDR_IRQ_STATUS);
   assign hit_address = (paddr == UEPA_ADDR_DMA_ADDRESS);
   assign hit_length = (paddr == UEPA_ADDR_DMA_LENGTH);
   assign hit_any = hit_enable | hit_clear | hit_status | hit_address
      | hit_length;

   // a write takes effect only at the completing access edge
   logic wr_stb;
   logic wr_enable;
   logic wr_clear;
   logic wr_address;
   logic wr_length;

   assign wr_stb = access_stb & pwrite;
   assign wr_enable = wr_stb & hit_enable;
   assign wr_clear = wr_stb & hit_clear;
   assign wr_address = wr_stb & hit_address;
   assign wr_length = wr_stb & hit_length;

   // byte-lane merge of write data with current contents
   logic [31:0] lane_mask;
   genvar b;
   generate
      for (b = 0; b < UEPA_STRB_W; b = b + 1) begin : g_lane
         assign lane_mask[8*b +: 8] = {8{pstrb[b]}};
      end
   endgenerate

   logic [31:0] enable_word;
   logic [31:0] length_word;
   logic [31:0] next_enable_word;
   logic [31:0] next_address;
   logic [31:0] next_length_word;

   assign enable_word = {{(32-UEPA_IRQ_W){1'b0}}, irq_enable};
   assign length_word = {12'h000, dma_length};
   assign next_enable_word = (pwdata & lane_mask) | (enable_word & ~lane_mask);
   assign next_address = (pwdata & lane_mask) | (dma_address & ~lane_mask);
   assign next_length_word = (pwdata & lane_mask) | (length_word & ~lane_mask);

   // clear pulses: ones written to the clear register, low lane only
   logic [UEPA_IRQ_W-1:0] clr_evt;
   assign clr_evt = wr_clear & pstrb[0] ? pwdata[UEPA_IRQ_W-1:0]
      : UEPA_RST_IRQ_STATUS;

   // event pulses laid out at their status positions
   logic [UEPA_IRQ_W-1:0] set_evt;
   assign set_evt[UEPA_BIT_CLEAR_FEATURE] = evt.clear_feature;
   assign set_evt[UEPA_BIT_BUS_ERROR] = evt.bus_error;
   assign set_evt[UEPA_BIT_DMA_DONE] = evt.dma_done;
   assign set_evt[UEPA_BIT_ALT_SETTING] = evt.alt_setting;
   assign set_evt[UEPA_BIT_TOKEN] = evt.token;
   assign set_evt[UEPA_BIT_STALL] = evt.stall;

   // read mux; clear register and unmapped space read zero
   logic [31:0] rd_word;
   assign rd_word = hit_enable ? enable_word
      : hit_status ? {{(32-UEPA_IRQ_W){1'b0}}, irq_status}
      : hit_address ? dma_address
      : hit_length ? length_word
      : UEPA_READ_ZERO;

   // apb handshake
   uepa_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pready(pready),
      .setup_stb(setup_stb),
      .access_stb(access_stb)
   );

   // sticky flags and interrupt request
   uepa_irq_bank u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .set_evt(set_evt),
      .clr_evt(clr_evt),
      .enable(irq_enable),
      .flag(irq_status),
      .irq(irq)
   );

   // enable register, reset to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable <= UEPA_RST_IRQ_ENABLE;
      end else if (wr_enable) begin
         irq_enable <= next_enable_word[UEPA_IRQ_W-1:0];
      end
   end

   // dma address register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_address <= UEPA_RST_DMA_ADDRESS;
      end else if (wr_address) begin
         dma_address <= next_address;
      end
   end

   // dma length register, reserved bits dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_length <= UEPA_RST_DMA_LENGTH;
      end else if (wr_length) begin
         dma_length <= next_length_word[UEPA_LEN_W-1:0];
      end
   end

   // dma setup copy toward the mover, updated after the write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_cfg <= '{address: UEPA_RST_DMA_ADDRESS,
            length: UEPA_RST_DMA_LENGTH};
      end else begin
         dma_cfg <= '{address: dma_address, length: dma_length};
      end
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= UEPA_READ_ZERO;
         pslverr <= 1'b0;
      end else if (setup_stb) begin
         prdata <= pwrite ? UEPA_READ_ZERO : rd_word;
         pslverr <= ~hit_any;
      end else if (access_stb) begin
         prdata <= UEPA_READ_ZERO;
         pslverr <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: include/uepa_pkg.sv */
// package: endpoint A register map, field layout, carriers and states
package uepa_pkg;

   // register byte addresses on the APB
   localparam logic [31:0] UEPA_ADDR_IRQ_ENABLE = 32'hFFF06050;
   localparam logic [31:0] UEPA_ADDR_IRQ_CLEAR = 32'hFFF06054;
   localparam logic [31:0] UEPA_ADDR_IRQ_STATUS = 32'hFFF06058;
   localparam logic [31:0] UEPA_ADDR_DMA_ADDRESS = 32'hFFF0605C;
   localparam logic [31:0] UEPA_ADDR_DMA_LENGTH = 32'hFFF06060;

   // interrupt field positions, shared by enable, clear and status
   localparam int UEPA_BIT_STALL = 0;
   localparam int UEPA_BIT_TOKEN = 1;
   localparam int UEPA_BIT_ALT_SETTING = 2;
   localparam int UEPA_BIT_DMA_DONE = 3;
   localparam int UEPA_BIT_BUS_ERROR = 4;
   localparam int UEPA_BIT_CLEAR_FEATURE = 5;
   localparam int UEPA_IRQ_W = 6;

   // field widths
   localparam int UEPA_DATA_W = 32;
   localparam int UEPA_LEN_W = 20;
   localparam int UEPA_STRB_W = 4;

   // reset values
   localparam logic [UEPA_IRQ_W-1:0] UEPA_RST_IRQ_ENABLE = 6'h00;
   localparam logic [UEPA_IRQ_W-1:0] UEPA_RST_IRQ_STATUS = 6'h00;
   localparam logic [31:0] UEPA_RST_DMA_ADDRESS = 32'h00000000;
   localparam logic [UEPA_LEN_W-1:0] UEPA_RST_DMA_LENGTH = 20'h00000;
   localparam logic [31:0] UEPA_READ_ZERO = 32'h00000000;

   // one pulse per interrupt source, packed msb first as bits 5..0
   typedef struct packed {
      logic clear_feature;
      logic bus_error;
      logic dma_done;
      logic alt_setting;
      logic token;
      logic stall;
   } uepa_evt_s;

   // transfer setup handed to the dma mover
   typedef struct packed {
      logic [31:0] address;
      logic [UEPA_LEN_W-1:0] length;
   } uepa_dma_cfg_s;

   // apb slave phase
   typedef enum logic [1:0] {
      UEPA_ST_IDLE = 2'b01,
      UEPA_ST_RESP = 2'b10
   } uepa_apb_state_e;

endpackage

/* File: core/uepa_apb_slave.sv */
// apb slave handshake: one wait-free access, pready from a flop
`timescale 1ns/100ps
`default_nettype none
module uepa_apb_slave (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   output logic pready,
   output logic setup_stb,
   output logic access_stb
);
   import uepa_pkg::*;

   uepa_apb_state_e state;
   uepa_apb_state_e next_state;

   // setup cycle seen while idle; access completes when pready is high
   assign setup_stb = psel & ~penable & (state == UEPA_ST_IDLE);
   assign access_stb = psel & penable & pready;

   // next phase
   always_comb begin
      case (state)
         UEPA_ST_IDLE: next_state = setup_stb ? UEPA_ST_RESP : UEPA_ST_IDLE;
         UEPA_ST_RESP: next_state = UEPA_ST_IDLE;
         default: next_state = UEPA_ST_IDLE;
      endcase
   end

   // state and ready flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= UEPA_ST_IDLE;
         pready <= 1'b0;
      end else begin
         state <= next_state;
         pready <= (next_state == UEPA_ST_RESP);
      end
   end
endmodule
`default_nettype wire

/* File: core/uepa_irq_bank.sv */
// sticky interrupt flags with write-one-to-clear and masked request
`timescale 1ns/100ps
`default_nettype none
module uepa_irq_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [uepa_pkg::UEPA_IRQ_W-1:0] set_evt,
   input wire logic [uepa_pkg::UEPA_IRQ_W-1:0] clr_evt,
   input wire logic [uepa_pkg::UEPA_IRQ_W-1:0] enable,
   output logic [uepa_pkg::UEPA_IRQ_W-1:0] flag,
   output logic irq
);
   import uepa_pkg::*;

   logic [UEPA_IRQ_W-1:0] next_flag;

   // per source: a set in the clear cycle wins
   genvar i;
   generate
      for (i = 0; i < UEPA_IRQ_W; i = i + 1) begin : g_flag
         assign next_flag[i] = set_evt[i] | (flag[i] & ~clr_evt[i]);
      end
   endgenerate

   // flags and request, both registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag <= UEPA_RST_IRQ_STATUS;
         irq <= 1'b0;
      end else begin
         flag <= next_flag;
         irq <= |(next_flag & enable);
      end
   end
endmodule
`default_nettype wire

/* File: tb/uepa_regs_chk.sv */
// port checker for the endpoint A register block
`timescale 1ns/100ps
`default_nettype none
module uepa_regs_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [uepa_pkg::UEPA_STRB_W-1:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire uepa_pkg::uepa_evt_s evt,
   input wire uepa_pkg::uepa_dma_cfg_s dma_cfg,
   input wire logic irq
);
   import uepa_pkg::*;
   logic [UEPA_IRQ_W-1:0] en_q;
   // bus phases, unmapped addresses, enable writes
   wire logic [UEPA_IRQ_W-1:0] ev = evt;
   wire logic setup = psel && !penable;
   wire logic done = psel && penable && pready;
   wire logic bad = !(paddr inside {UEPA_ADDR_IRQ_ENABLE, UEPA_ADDR_IRQ_CLEAR,
      UEPA_ADDR_IRQ_STATUS, UEPA_ADDR_DMA_ADDRESS, UEPA_ADDR_DMA_LENGTH});
   wire logic en_wr = done && pwrite && pstrb[0]
      && paddr == UEPA_ADDR_IRQ_ENABLE;
   // shadow of the enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= '0;
      end else if (en_wr) begin
         en_q <= pwdata[UEPA_IRQ_W-1:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr; done && pwrite; endsequence
   sequence s_rd; done && !pwrite; endsequence
   property p_ready; setup |=> pready; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_err; setup |=> pslverr == $past(bad); endproperty
   property p_rclr;
      s_rd ##0 (paddr == UEPA_ADDR_IRQ_CLEAR) |-> prdata == '0;
   endproperty
   property p_rsts;
      s_rd ##0 (paddr == UEPA_ADDR_IRQ_STATUS) |-> prdata[31:6] == '0;
   endproperty
   property p_rlen;
      s_rd ##0 (paddr == UEPA_ADDR_DMA_LENGTH) |-> prdata[31:20] == '0;
   endproperty
   property p_addr;
      s_wr ##0 (paddr == UEPA_ADDR_DMA_ADDRESS && pstrb == 4'hF)
         |=> ##1 dma_cfg.address == $past(pwdata, 2);
   endproperty
   property p_len;
      s_wr ##0 (paddr == UEPA_ADDR_DMA_LENGTH && pstrb == 4'hF)
         |=> ##1 dma_cfg.length == 20'($past(pwdata, 2));
   endproperty
   property p_iset; (ev & en_q) != '0 |=> irq; endproperty
   property p_mask; en_q == '0 |=> !irq; endproperty
   property p_clr;
      s_wr ##0 (paddr == UEPA_ADDR_IRQ_CLEAR && pstrb[0]
         && pwdata[5:0] == 6'h3F && ev == '0) |=> !irq;
   endproperty
   a_ready: assert property (p_ready) else $error("ready missing");
   a_pulse: assert property (p_pulse) else $error("ready too long");
   a_err: assert property (p_err) else $error("error flag wrong");
   a_rclr: assert property (p_rclr) else $error("clear reads set");
   a_rsts: assert property (p_rsts) else $error("status high bits");
   a_rlen: assert property (p_rlen) else $error("length high bits");
   a_addr: assert property (p_addr) else $error("address lost");
   a_len: assert property (p_len) else $error("length lost");
   a_iset: assert property (p_iset) else $error("irq not raised");
   a_mask: assert property (p_mask) else $error("irq not masked");
   a_clr: assert property (p_clr) else $error("irq not cleared");
endmodule
bind uepa_regs uepa_regs_chk chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .evt(evt), .dma_cfg(dma_cfg), .irq(irq));
`default_nettype wire

/* File: tb/uepa_regs_tb_top.sv */
// self-checking bench for the endpoint A register block
`timescale 1ns/100ps
`default_nettype none
module uepa_regs_tb_top;
   import uepa_pkg::*;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb;
   uepa_evt_s evt;
   uepa_dma_cfg_s dma_cfg;
   int bad_count = 0;
   int total_checks = 0;
   // clock
   always #5 pclk = ~pclk;
   uepa_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .evt(evt), .dma_cfg(dma_cfg), .irq(irq));
   // one apb transfer, held until ready
   task automatic xfer(input logic w, input logic [31:0] a, d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdchk(input logic [31:0] a, e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic irqchk(input logic e);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   task automatic pulse(input logic [5:0] v);
      @(posedge pclk);
      evt <= v;
      @(posedge pclk);
      evt <= '0;
   endtask
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #50000;
      bad_count++;
      end_of_test();
   end
   // main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'hF;
      evt = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(UEPA_ADDR_IRQ_ENABLE, 32'h0);
      rdchk(UEPA_ADDR_IRQ_CLEAR, 32'h0);
      rdchk(UEPA_ADDR_IRQ_STATUS, 32'h0);
      rdchk(UEPA_ADDR_DMA_ADDRESS, 32'h0);
      rdchk(UEPA_ADDR_DMA_LENGTH, 32'h0);
      // unmapped address
      rdchk(32'hFFF06064, 32'h0);
      chk({31'h0, er}, 32'h1);
      // field widths and read-only status
      xfer(1'b1, UEPA_ADDR_DMA_ADDRESS, 32'hA5C3_0F96);
      xfer(1'b1, UEPA_ADDR_DMA_LENGTH, 32'hFFFF_FFFF);
      xfer(1'b1, UEPA_ADDR_IRQ_STATUS, 32'hFFFF_FFFF);
      xfer(1'b1, UEPA_ADDR_IRQ_ENABLE, 32'hFFFF_FFFF);
      rdchk(UEPA_ADDR_DMA_ADDRESS, 32'hA5C3_0F96);
      rdchk(UEPA_ADDR_DMA_LENGTH, 32'h000F_FFFF);
      rdchk(UEPA_ADDR_IRQ_STATUS, 32'h0);
      rdchk(UEPA_ADDR_IRQ_ENABLE, 32'h3F);
      chk(dma_cfg.address, 32'hA5C3_0F96);
      chk({12'h0, dma_cfg.length}, 32'h000F_FFFF);
      // partial lane write keeps the upper bytes
      pstrb <= 4'h3;
      xfer(1'b1, UEPA_ADDR_DMA_ADDRESS, 32'h1234_5678);
      pstrb <= 4'hF;
      rdchk(UEPA_ADDR_DMA_ADDRESS, 32'hA5C3_5678);
      // each source on its own
      for (int i = 0; i < UEPA_IRQ_W; i++) begin
         pulse(6'h01 << i);
         rdchk(UEPA_ADDR_IRQ_STATUS, 32'h1 << i);
         irqchk(1'b1);
         xfer(1'b1, UEPA_ADDR_IRQ_CLEAR, 32'h1 << i);
         rdchk(UEPA_ADDR_IRQ_STATUS, 32'h0);
         irqchk(1'b0);
      end
      // masking and partial clear
      xfer(1'b1, UEPA_ADDR_IRQ_ENABLE, 32'h0);
      pulse(6'h3F);
      irqchk(1'b0);
      xfer(1'b1, UEPA_ADDR_IRQ_CLEAR, 32'h37);
      rdchk(UEPA_ADDR_IRQ_STATUS, 32'h08);
      xfer(1'b1, UEPA_ADDR_IRQ_ENABLE, 32'h08);
      @(posedge pclk);
      irqchk(1'b1);
      xfer(1'b1, UEPA_ADDR_IRQ_CLEAR, 32'h3F);
      irqchk(1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
